// File: rtl/hsg_pkg.sv
// Purpose : shared constants and types for the response gap link
// Assumes : core clock of 200 MHz, SPI mode 0, MSB first
// Notes   : lock, gap, watchdog and busy times are kept in their own unit, counts derived here; sck half and select gap in cycles

package hsg_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ       = 200;
  localparam int LOCK_TIME_US  = 1000;               // freeze after readout
  localparam int LOCK_CYC      = LOCK_TIME_US * CLK_MHZ;
  localparam int GAP_TIME_US   = 1100;               // host gap after readout
  localparam int GAP_CYC       = GAP_TIME_US * CLK_MHZ;
  localparam int WDOG_TIME_MS  = 1000;               // watchdog period
  localparam int WDOG_CYC      = WDOG_TIME_MS * 1000 * CLK_MHZ;
  localparam int BUSY_TIME_US  = 1;                  // command processing
  localparam int BUSY_CYC      = BUSY_TIME_US * CLK_MHZ;
  localparam int SCK_HALF_CYC  = 4;                  // 25 MHz serial clock
  localparam int CS_GAP_CYC    = 4;                  // select high hold
  localparam int CNT_W         = 28;
  localparam int DIV_W         = 8;

  // ==========================================================
  // byte codes and response words
  localparam logic [7:0]  READ_BYTE    = 8'h00;      // plain readout byte
  localparam logic [7:0]  DUMMY_BYTE   = 8'hFF;      // unsupported command
  localparam logic [15:0] RESP_OK      = 16'h9000;
  localparam logic [15:0] RESP_ERR_CMD = 16'h6D00;   // unknown command
  localparam logic [15:0] RESP_NONE    = 16'h0000;   // nothing pending
  localparam logic [1:0]  RD_LAST      = 2'h1;       // readout is 2 bytes
  localparam logic [1:0]  NB_SAT       = 2'h2;

  // ==========================================================
  // host operations
  typedef enum logic [1:0] {
    OP_CMD,
    OP_CMD_OVL,
    OP_RD_ZERO,
    OP_RD_DUMMY
  } hsg_op_t;

  // error unless ok or empty
  function automatic logic resp_is_err(input logic [15:0] r);
    resp_is_err = (r != RESP_OK) && (r != RESP_NONE);
  endfunction : resp_is_err

endpackage : hsg_pkg

// File: rtl/hsg_link_if.sv
// Purpose : serial link between host master and panel controller
// Assumes : all signals synchronous to the shared core clock
// Notes   : no two-way pins on this link

`timescale 1ns/1ps

interface hsg_link_if;
  logic sck;             // serial clock, idle low
  logic cs_n;            // frame select, active low
  logic mosi;            // master out
  logic miso;            // slave out
  logic controller_busy_n; // command processing, active low

  modport host (
    output sck, cs_n, mosi,
    input  miso, controller_busy_n
  );
  modport dev (
    input  sck, cs_n, mosi,
    output miso, controller_busy_n
  );
endinterface : hsg_link_if

// File: rtl/hsg_dev.sv
// Purpose : panel_controller end of the link, with the readout freeze
// Assumes : host obeys gap and busy; lock_en_i models the chance
// Notes   : freeze state never shows on any link pin

`timescale 1ns/1ps

module hsg_dev
  import hsg_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_CYC,
  parameter int WDOG_CYCLES = WDOG_CYC,
  parameter int BUSY_CYCLES = BUSY_CYC
) (
  input  logic        core_clk_i,   // core clock
  input  logic        reset_n_i,    // async reset, active low
  input  logic        clk_en_i,     // freezes state when low
  hsg_link_if.dev     link,         // serial link
  input  logic        lock_en_i,    // readout freezes this time
  input  logic        hang_now_i,   // hang resets at once
  input  logic [15:0] resp_i,       // answer to a supported command
  output logic [7:0]  rx_data_o,    // received byte
  output logic        rx_valid_o,   // received byte pulse
  output logic        frame_done_o, // frame end pulse
  output logic        ctl_reset_o   // internal reset pulse after hang
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_XFER, ST_BUSY, ST_LOCK, ST_HANG
  } hsg_dst_t;

  hsg_dst_t         state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic             sck_q_ff, cs_q_ff;
  logic [2:0]       bit_ff;
  logic [7:0]       sh_ff, first_ff, rx_data_ff;
  logic             got_ff, zero_ff;
  logic [15:0]      resp_ff, tx_ff;
  logic             rx_valid_ff, done_ff, rst_ff, busy_n_ff;

  // ==========================================================
  // link edge decode
  wire        sck_rise  = link.sck & ~sck_q_ff;
  wire        sck_fall  = ~link.sck & sck_q_ff;
  wire        cs_fall   = ~link.cs_n & cs_q_ff;
  wire        cs_rise   = link.cs_n & ~cs_q_ff;
  wire        in_xfer   = (state_ff == ST_XFER) & ~link.cs_n;
  wire        byte_end  = in_xfer & sck_rise & (bit_ff == 3'h7);
  wire [7:0]  byte_val  = {sh_ff[6:0], link.mosi};
  wire        readout   = got_ff & zero_ff;
  wire        cnt_zero  = (cnt_ff == '0);
  wire        busy_end  = (state_ff == ST_BUSY) & cnt_zero;
  wire        hang_end  = (state_ff == ST_HANG) & cnt_zero;
  wire [15:0] busy_resp = (first_ff == DUMMY_BYTE) ? RESP_ERR_CMD : resp_i;

  // next state and counter
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_zero ? cnt_ff : cnt_ff - 1'b1;
    case (state_ff)
      ST_IDLE: begin
        if (cs_fall) begin
          nxt_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (cs_rise) begin
          if (readout && lock_en_i) begin
            nxt_state = ST_LOCK;
            nxt_cnt   = CNT_W'(LOCK_CYCLES - 1);
          end else if (got_ff && !zero_ff) begin
            nxt_state = ST_BUSY;
            nxt_cnt   = CNT_W'(BUSY_CYCLES - 1);
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_BUSY: begin
        if (cnt_zero) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_LOCK: begin
        if (cs_fall) begin
          nxt_state = ST_HANG;
          nxt_cnt   = hang_now_i ? '0 : CNT_W'(WDOG_CYCLES - 1);
        end else if (cnt_zero) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_HANG: begin
        if (cnt_zero) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state, counter and pin history
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      sck_q_ff <= 1'b0;
      cs_q_ff  <= 1'b1;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      sck_q_ff <= link.sck;
      cs_q_ff  <= link.cs_n;
    end
  end

  // receive shifter and frame classification
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_ff   <= 3'h0;
      sh_ff    <= 8'h00;
      first_ff <= 8'h00;
      got_ff   <= 1'b0;
      zero_ff  <= 1'b1;
    end else if (clk_en_i) begin
      if (state_ff == ST_IDLE && cs_fall) begin
        bit_ff  <= 3'h0;
        got_ff  <= 1'b0;
        zero_ff <= 1'b1;
      end else if (in_xfer && sck_rise) begin
        bit_ff <= bit_ff + 3'h1;
        sh_ff  <= byte_val;
        if (byte_end) begin
          got_ff <= 1'b1;
          if (byte_val != READ_BYTE) begin
            zero_ff <= 1'b0;
          end
          if (!got_ff) begin
            first_ff <= byte_val;
          end
        end
      end
    end
  end

  // pending response and its output shifter
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      resp_ff <= RESP_NONE;
      tx_ff   <= RESP_NONE;
    end else if (clk_en_i) begin
      if (hang_end) begin
        resp_ff <= RESP_NONE;
      end else if (busy_end) begin
        resp_ff <= busy_resp;
      end else if (state_ff == ST_IDLE && cs_fall) begin
        resp_ff <= RESP_NONE;
        tx_ff   <= resp_ff;
      end
      if (in_xfer && sck_fall) begin
        tx_ff <= {tx_ff[14:0], 1'b0};
      end
    end
  end

  // user pulses and busy pin; lock leaves busy high
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_data_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
      done_ff     <= 1'b0;
      rst_ff      <= 1'b0;
      busy_n_ff   <= 1'b1;
    end else if (clk_en_i) begin
      rx_valid_ff <= byte_end;
      if (byte_end) begin
        rx_data_ff <= byte_val;
      end
      done_ff   <= (state_ff == ST_XFER) & cs_rise;
      rst_ff    <= hang_end;
      busy_n_ff <= (nxt_state != ST_BUSY);
    end
  end

  assign link.miso              = tx_ff[15];
  assign link.controller_busy_n = busy_n_ff;
  assign rx_data_o              = rx_data_ff;
  assign rx_valid_o             = rx_valid_ff;
  assign frame_done_o           = done_ff;
  assign ctl_reset_o            = rst_ff;

endmodule : hsg_dev

// File: rtl/hsg_host.sv
// Purpose : host master end of the link with readout workarounds
// Assumes : controller follows SPI mode 0, response is two bytes
// Notes   : ops are plain command, overlapped command, zero readout
//           and dummy readout

`timescale 1ns/1ps

module hsg_host
  import hsg_pkg::*;
#(
  parameter int GAP_CYCLES      = GAP_CYC,
  parameter int SCK_HALF_CYCLES = SCK_HALF_CYC,
  parameter int CS_GAP_CYCLES   = CS_GAP_CYC
) (
  input  logic        core_clk_i,   // core clock
  input  logic        reset_n_i,    // async reset, active low
  input  logic        clk_en_i,     // freezes state when low
  hsg_link_if.host    link,         // serial link
  input  hsg_op_t     op_i,         // operation kind
  input  logic        op_valid_i,   // operation request
  output logic        op_ready_o,   // operation accepted when high
  input  logic [7:0]  tx_data_i,    // command byte
  input  logic        tx_last_i,    // last byte of command
  input  logic        tx_valid_i,   // command byte valid
  output logic        tx_ready_o,   // command byte taken
  output logic [7:0]  rx_data_o,    // byte seen on slave out
  output logic        rx_valid_o,   // received byte pulse
  output logic [15:0] resp_o,       // first two bytes of a frame
  output logic        resp_valid_o, // response pulse
  output logic        resp_err_o,   // response is a live error
  output logic        abort_o,      // frame cut short pulse
  output logic        done_o        // operation finished pulse
);

  typedef enum logic [2:0] {
    H_IDLE, H_WAIT, H_LOAD, H_SHIFT, H_FLUSH, H_END
  } hsg_hst_t;

  hsg_hst_t         state_ff, nxt_state;
  hsg_op_t          op_ff;
  logic [CNT_W-1:0] gap_ff;
  logic [DIV_W-1:0] div_ff;
  logic             sck_ff, cs_n_ff, last_ff, ign_ff;
  logic [7:0]       tx_sh_ff, rx_sh_ff, b0_ff, rx_data_ff;
  logic [2:0]       bit_ff;
  logic [1:0]       nb_ff;
  logic [15:0]      resp_ff;
  logic             rx_valid_ff, resp_valid_ff, resp_err_ff;
  logic             abort_ff, done_ff;

  // ==========================================================
  // decode of the current step
  wire        is_cmd    = (op_ff == OP_CMD) | (op_ff == OP_CMD_OVL);
  wire [7:0]  rd_byte   = (op_ff == OP_RD_DUMMY) ? DUMMY_BYTE : READ_BYTE;
  wire        sck_tick  = div_ff == DIV_W'(SCK_HALF_CYCLES - 1);
  wire        end_tick  = div_ff == DIV_W'(CS_GAP_CYCLES - 1);
  wire        in_shift  = (state_ff == H_SHIFT);
  wire        rise      = in_shift & sck_tick & ~sck_ff;
  wire        fall      = in_shift & sck_tick & sck_ff;
  wire        byte_done = fall & (bit_ff == 3'h7);
  wire        second    = byte_done & (nb_ff == RD_LAST);
  wire [15:0] resp_word = {b0_ff, rx_sh_ff};
  wire        live_err  = resp_is_err(resp_word) & ~ign_ff;
  wire        abort_now = second & (op_ff == OP_CMD_OVL) & live_err;
  wire        load_ok   = (state_ff == H_LOAD) & (~is_cmd | tx_valid_i);
  wire        flush_end = (state_ff == H_FLUSH) & tx_valid_i & tx_last_i;
  wire        end_done  = (state_ff == H_END) & end_tick;
  wire        gap_clear = (gap_ff == '0);

  // request is taken only when idle and the gap has run out
  assign op_ready_o = (state_ff == H_IDLE) & gap_clear;
  assign tx_ready_o = ((state_ff == H_LOAD) & is_cmd) |
                      (state_ff == H_FLUSH);

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      H_IDLE: begin
        if (op_valid_i && op_ready_o) begin
          nxt_state = H_WAIT;
        end
      end
      H_WAIT: begin
        // no pin shows a freeze, only busy is honoured here
        if (link.controller_busy_n) begin
          nxt_state = H_LOAD;
        end
      end
      H_LOAD: begin
        if (load_ok) begin
          nxt_state = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (abort_now) begin
          nxt_state = last_ff ? H_END : H_FLUSH;
        end else if (byte_done) begin
          nxt_state = last_ff ? H_END : H_LOAD;
        end
      end
      H_FLUSH: begin
        if (flush_end) begin
          nxt_state = H_END;
        end
      end
      H_END: begin
        if (end_tick) begin
          nxt_state = H_IDLE;
        end
      end
      default: begin
        nxt_state = H_IDLE;
      end
    endcase
  end

  // state, operation and divider
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= H_IDLE;
      op_ff    <= OP_CMD;
      div_ff   <= '0;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      if (state_ff == H_IDLE && nxt_state == H_WAIT) begin
        op_ff <= op_i;
      end
      if (state_ff != nxt_state || (in_shift && sck_tick)) begin
        div_ff <= '0;
      end else if (in_shift || state_ff == H_END) begin
        div_ff <= div_ff + 1'b1;
      end
    end
  end

  // gap after a zero readout only, not after a dummy readout or a command
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap_ff <= '0;
    end else if (clk_en_i) begin
      if (end_done && op_ff == OP_RD_ZERO) begin
        gap_ff <= CNT_W'(GAP_CYCLES);
      end else if (!gap_clear) begin
        gap_ff <= gap_ff - 1'b1;
      end
    end
  end

  // serial pins
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_ff  <= 1'b0;
      cs_n_ff <= 1'b1;
    end else if (clk_en_i) begin
      if (in_shift && sck_tick) begin
        sck_ff <= ~sck_ff;
      end else if (!in_shift) begin
        sck_ff <= 1'b0;
      end
      cs_n_ff <= ~((nxt_state == H_LOAD) || (nxt_state == H_SHIFT));
    end
  end

  // transmit and receive shifters
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_sh_ff <= 8'h00;
      rx_sh_ff <= 8'h00;
      last_ff  <= 1'b0;
      bit_ff   <= 3'h0;
    end else if (clk_en_i) begin
      if (load_ok) begin
        // readout sends two plain or dummy bytes
        tx_sh_ff <= is_cmd ? tx_data_i : rd_byte;
        last_ff  <= is_cmd ? tx_last_i : (nb_ff == RD_LAST);
        bit_ff   <= 3'h0;
      end else if (fall) begin
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
        bit_ff   <= bit_ff + 3'h1;
      end
      if (rise) begin
        rx_sh_ff <= {rx_sh_ff[6:0], link.miso};
      end
    end
  end

  // byte count and response capture
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nb_ff         <= 2'h0;
      b0_ff         <= 8'h00;
      rx_data_ff    <= 8'h00;
      rx_valid_ff   <= 1'b0;
      resp_ff       <= RESP_NONE;
      resp_valid_ff <= 1'b0;
      resp_err_ff   <= 1'b0;
      ign_ff        <= 1'b0;
    end else if (clk_en_i) begin
      rx_valid_ff   <= byte_done;
      resp_valid_ff <= second;
      if (state_ff == H_WAIT) begin
        nb_ff <= 2'h0;
      end else if (byte_done) begin
        rx_data_ff <= rx_sh_ff;
        nb_ff      <= (nb_ff == NB_SAT) ? NB_SAT : nb_ff + 2'h1;
        if (nb_ff == 2'h0) begin
          b0_ff <= rx_sh_ff;
        end
      end
      if (second) begin
        resp_ff     <= resp_word;
        resp_err_ff <= live_err;
        ign_ff      <= (op_ff == OP_RD_DUMMY);
      end
    end
  end

  // completion pulses
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      abort_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else if (clk_en_i) begin
      abort_ff <= abort_now;
      done_ff  <= end_done;
    end
  end

  assign link.sck     = sck_ff;
  assign link.cs_n    = cs_n_ff;
  assign link.mosi    = tx_sh_ff[7];
  assign rx_data_o    = rx_data_ff;
  assign rx_valid_o   = rx_valid_ff;
  assign resp_o       = resp_ff;
  assign resp_valid_o = resp_valid_ff;
  assign resp_err_o   = resp_err_ff;
  assign abort_o      = abort_ff;
  assign done_o       = done_ff;

endmodule : hsg_host

// File: verif/hsg_link_monitor.sv
// Purpose : link checker for the response gap link
// Assumes : serial clock half period of 4 cycles, select gap of 4
// Notes   : sees only the link wires, the clock and the reset

`timescale 1ns/1ps

module hsg_link_monitor #(
  parameter int BUSY_CYCLES = 20
) (
  input logic core_clk_i,        // core clock
  input logic reset_n_i,         // async reset, active low
  input logic sck,               // serial clock
  input logic cs_n,              // frame select
  input logic mosi,              // master out
  input logic miso,              // slave out
  input logic controller_busy_n  // busy, active low
);
  // ==========================================================
  // helper state
  logic        nz_ff;
  logic        sck_q_ff;
  logic [15:0] busy_cnt_ff;
  wire         sck_up       = sck & ~sck_q_ff;
  wire         nxt_nz       = cs_n ? 1'b0 : (nz_ff | (sck_up & mosi));
  wire  [15:0] nxt_busy_cnt = controller_busy_n ? 16'h0000
                                                : busy_cnt_ff + 16'h0001;

  // nonzero frame flag and busy length
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nz_ff       <= 1'b0;
      sck_q_ff    <= 1'b0;
      busy_cnt_ff <= 16'h0000;
    end else begin
      nz_ff       <= nxt_nz;
      sck_q_ff    <= sck;
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end

  default clocking mon_cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // ==========================================================
  // wire rules
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock high outside a frame");
  mosi_hold_a: assert property ($rose(sck) |-> $stable(mosi))
    else $error("master out moved at a sampling edge");
  miso_hold_a: assert property ($rose(sck) |-> $stable(miso))
    else $error("slave out moved at a sampling edge");
  sck_half_a: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("serial clock high phase not 4 cycles");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n[*4])
    else $error("select high shorter than 4 cycles");
  no_busy_zero_a: assert property (
    $rose(cs_n) && !nz_ff |-> controller_busy_n[*4])
    else $error("busy pulse after a zero frame");
  busy_cmd_a: assert property (
    $rose(cs_n) && nz_ff && controller_busy_n |-> ##[1:3] !controller_busy_n)
    else $error("no busy after a command frame");
  busy_start_a: assert property (
    $fell(controller_busy_n) |-> cs_n && $past(cs_n))
    else $error("busy started inside a frame");
  busy_len_a: assert property (
    $rose(controller_busy_n) |-> busy_cnt_ff == BUSY_CYCLES)
    else $error("busy low time off");

  // main scenarios
  busy_seen_c: cover property ($fell(controller_busy_n));
  zero_frame_c: cover property ($rose(cs_n) && !nz_ff);
  cmd_frame_c: cover property ($rose(cs_n) && nz_ff);
endmodule : hsg_link_monitor

// File: verif/host_spi_response_gap_test.sv
// Purpose : self-checking bench for the response gap link
// Assumes : shortened gap, freeze, watchdog and busy counts
// Notes   : second link is driven by a host that ignores the gap

`timescale 1ns/1ps

module host_spi_response_gap_test;
  import hsg_pkg::*;
  localparam int GAP = 300;
  localparam int WDOG = 50;
  localparam int BUSY = 20;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i  = 1'b0;
  logic        run_en     = 1'b1;
  hsg_op_t     op_i       = OP_CMD;
  logic        op_valid_i = 1'b0;
  logic [7:0]  tx_data_i  = 8'h00;
  logic        tx_last_i  = 1'b0;
  logic        tx_valid_i = 1'b0;
  logic        lock_en_i  = 1'b0;
  logic        hang_now_i = 1'b0;
  logic [15:0] resp_i     = 16'h0000;
  logic        hn_b       = 1'b0;
  logic        op_ready_o, tx_ready_o, resp_valid_o, resp_err_o;
  logic        abort_o, done_o, rst_a, rst_b;
  logic [15:0] resp_o, got, pend;
  logic        hang_a = 1'b0, busy_b = 1'b0, abort_q = 1'b0, mask = 1'b0;
  logic        sck_q  = 1'b0;
  logic [7:0]  w_byte = 8'h00;
  logic [7:0]  d_rx, h_rxd, d_byte = 8'h00, h_rx = 8'h00;
  logic        d_rv, d_fd, h_rv, d_first = 1'b1;
  int          fd_cnt = 0;
  logic [31:0] sel;
  int          nbit = 0, t = 0, n_fail = 0, comparisons = 0;
  int          seed = 32'h8540b055;

  always #2.5 core_clk_i = ~core_clk_i;

  // ==========================================================
  // design ends
  hsg_link_if u_hsg_link_if ();
  hsg_link_if u_link_b ();
  hsg_host #(.GAP_CYCLES(GAP)) u_hsg_host (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .clk_en_i(run_en), .link(u_hsg_link_if),
    .op_i(op_i), .op_valid_i(op_valid_i), .op_ready_o(op_ready_o),
    .tx_data_i(tx_data_i), .tx_last_i(tx_last_i), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .rx_data_o(h_rxd), .rx_valid_o(h_rv),
    .resp_o(resp_o),
    .resp_valid_o(resp_valid_o), .resp_err_o(resp_err_o),
    .abort_o(abort_o), .done_o(done_o));
  hsg_dev #(.LOCK_CYCLES(200), .WDOG_CYCLES(WDOG), .BUSY_CYCLES(BUSY))
    u_hsg_dev (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(run_en), .link(u_hsg_link_if), .lock_en_i(lock_en_i),
    .hang_now_i(hang_now_i), .resp_i(resp_i), .rx_data_o(d_rx),
    .rx_valid_o(d_rv), .frame_done_o(d_fd), .ctl_reset_o(rst_a));
  hsg_dev #(.LOCK_CYCLES(200), .WDOG_CYCLES(WDOG), .BUSY_CYCLES(BUSY))
    u_hsg_dev_b (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(run_en), .link(u_link_b), .lock_en_i(1'b1),
    .hang_now_i(hn_b), .resp_i(RESP_OK), .rx_data_o(), .rx_valid_o(),
    .frame_done_o(), .ctl_reset_o(rst_b));
  hsg_link_monitor #(.BUSY_CYCLES(BUSY)) u_hsg_link_monitor (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .sck(u_hsg_link_if.sck), .cs_n(u_hsg_link_if.cs_n),
    .mosi(u_hsg_link_if.mosi), .miso(u_hsg_link_if.miso),
    .controller_busy_n(u_hsg_link_if.controller_busy_n));

  // capture of results and of the first byte on the wire
  always @(negedge core_clk_i) begin
    if (resp_valid_o) got <= resp_o;
    if (abort_o) abort_q <= 1'b1;
    if (rst_a) hang_a <= 1'b1;
    if (!u_link_b.controller_busy_n) busy_b <= 1'b1;
    if (h_rv) h_rx <= h_rxd;
    if (d_fd) fd_cnt <= fd_cnt + 1;
    if (u_hsg_link_if.cs_n) d_first <= 1'b1;
    else if (d_rv && d_first) begin
      d_byte  <= d_rx;
      d_first <= 1'b0;
    end
    sck_q <= u_hsg_link_if.sck;
    if (u_hsg_link_if.cs_n) nbit <= 0;
    else if (u_hsg_link_if.sck && !sck_q && nbit < 8) begin
      w_byte <= {w_byte[6:0], u_hsg_link_if.mosi};
      nbit   <= nbit + 1;
    end
  end

  // ==========================================================
  // tasks
  task automatic wrap_up();
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_word

  task automatic cmp_flag(input logic g, input logic e);
    cmp_word({15'h0000, g}, {15'h0000, e});
  endtask : cmp_flag

  // bounded wait for a high level, counting falling edges
  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
      if (n > 5000) begin
        n_fail++;
        wrap_up();
      end
    end while (s !== 1'b1);
  endtask : wait_hi

  // one host operation with its expected answer
  task automatic run_op(input hsg_op_t op, input logic [7:0] b0,
                        input int n);
    logic [15:0] e_resp;
    logic        e_err;
    logic [7:0]  e_last;
    int          fd0;
    e_resp = pend;
    e_err  = pend !== RESP_OK && pend !== RESP_NONE && !mask;
    e_last = (n > 2 && !(op == OP_CMD_OVL && e_err)) ? 8'h00 : pend[7:0];
    fd0    = fd_cnt;
    wait_hi(op_ready_o, t);
    @(posedge core_clk_i);
    op_i       <= op;
    op_valid_i <= 1'b1;
    lock_en_i  <= 1'($random(seed));
    hang_now_i <= 1'($random(seed));
    abort_q    =  1'b0;
    got        =  'x;
    @(posedge core_clk_i);
    op_valid_i <= 1'b0;
    for (int k = 0; k < n; k++) begin
      tx_data_i  <= (k == 0) ? b0 : 8'($random(seed));
      tx_last_i  <= (k == n - 1);
      tx_valid_i <= 1'b1;
      wait_hi(tx_ready_o, t);
      @(posedge core_clk_i);
    end
    tx_valid_i <= 1'b0;
    wait_hi(done_o, t);
    cmp_word(got, e_resp);
    cmp_flag(resp_err_o, e_err);
    cmp_flag(abort_q, op == OP_CMD_OVL && e_err);
    cmp_word({8'h00, w_byte}, {8'h00, b0});
    cmp_word({8'h00, d_byte}, {8'h00, b0});
    cmp_word({8'h00, h_rx}, {8'h00, e_last});
    cmp_flag(fd_cnt - fd0 == 1, 1'b1);
    if (op == OP_RD_ZERO) begin
      wait_hi(op_ready_o, t);
      cmp_flag(t >= GAP - 1 && t <= GAP + 3, 1'b1);
    end
    mask = (op == OP_RD_DUMMY);
    pend = (b0 == 8'h00) ? RESP_NONE :
           (b0 == 8'hFF) ? RESP_ERR_CMD : resp_i;
  endtask : run_op

  // zero readout frame from the rule-breaking host
  task automatic zero_frame_b();
    u_link_b.cs_n <= 1'b0;
    u_link_b.mosi <= 1'b0;
    repeat (32) begin
      repeat (4) @(posedge core_clk_i);
      u_link_b.sck <= ~u_link_b.sck;
    end
    repeat (4) @(posedge core_clk_i);
    u_link_b.cs_n <= 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask : zero_frame_b

  // ==========================================================
  // main sequence
  initial begin
    u_link_b.sck  = 1'b0;
    u_link_b.cs_n = 1'b1;
    u_link_b.mosi = 1'b0;
    pend = RESP_NONE;
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(negedge core_clk_i);
    cmp_flag(op_ready_o, 1'b1);
    cmp_flag(u_hsg_link_if.controller_busy_n, 1'b1);
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk_i);
      sel = $random(seed);
      resp_i <= (i % 3 == 0) ? RESP_OK :
                (i % 3 == 1) ? RESP_ERR_CMD : sel[31:16];
      @(posedge core_clk_i);
      run_op(OP_CMD, (i == 1) ? 8'hFF : (sel[7:0] | 8'h01), 2);
      case (i % 4)
        0: run_op(OP_RD_ZERO, 8'h00, 0);
        1: run_op(OP_CMD_OVL, sel[15:8] | 8'h01, 3);
        2: begin
          run_op(OP_RD_DUMMY, 8'hFF, 0);
          run_op(OP_RD_ZERO, 8'h00, 0);
        end
        default: begin
          run_op(OP_CMD_OVL, sel[23:16] | 8'h01, 2);
          run_op(OP_RD_ZERO, 8'h00, 0);
        end
      endcase
      wait_hi(u_hsg_link_if.controller_busy_n, t);
    end
    // traffic inside the freeze, watchdog then at once
    for (int h = 0; h < 2; h++) begin
      @(posedge core_clk_i);
      hn_b <= h[0];
      zero_frame_b();
      u_link_b.cs_n <= 1'b0;
      wait_hi(rst_b, t);
      cmp_flag(h ? t <= 4 : (t >= WDOG - 2 && t <= WDOG + 6),
               1'b1);
      @(posedge core_clk_i);
      u_link_b.cs_n <= 1'b1;
      u_link_b.mosi <= 1'b1;
    end
    cmp_flag(busy_b, 1'b0);
    cmp_flag(hang_a, 1'b0);
    wrap_up();
  end
endmodule : host_spi_response_gap_test
